/* tdm_slot_pkg.sv */
// Purpose: Shared constants for the TDM timeslot assigner and its bus end
// Assumes: 4.096 MHz data clock, 8 kHz frame, so 512 bit times per frame
// Notes:   Register indices are word addresses on the Avalon-MM port
package tdm_slot_pkg;
  // ==========================================================
  // Frame geometry
  localparam int FRAME_BITS  = 512;
  localparam int CNT_W       = 9;
  localparam int SLOT_BITS   = 2;
  localparam int GCI_SLOT_W  = 32;
  localparam int GCI_SLOTS   = 8;
  localparam int NCH         = 3;
  localparam logic [CNT_W:0]   CH_LEN  [0:NCH-1] = '{10'h008, 10'h008, 10'h002};
  localparam logic [CNT_W-1:0] GCI_OFS [0:NCH-1] = '{9'h000, 9'h008, 9'h018};

  // ==========================================================
  // Register indices, normal group
  localparam logic [3:0] REG_SOFT_RESET  = 4'h0;
  localparam logic [3:0] REG_CONFIG      = 4'h1;
  localparam logic [3:0] REG_STATUS      = 4'h2;
  localparam logic [3:0] REG_OVERLAY_SEL = 4'ha;
  // Overlay group; starts are tx B1,B2,D then rx B1,B2,D
  localparam logic [3:0] OR_START_BASE   = 4'h0;
  localparam logic [3:0] OR_GCI_SLOT     = 4'h6;
  localparam logic [3:0] OR_SLOT_ENABLE  = 4'h9;
  localparam logic [3:0] OR_OVERLAY_ALIAS = 4'ha;

  // ==========================================================
  // Field positions and reset values
  localparam int OVL_SEL_BIT    = 0;
  localparam int SOFT_RST_BIT   = 3;
  localparam int CFG_GCI_BIT    = 0;
  localparam int GCI_EN_BIT     = 3;
  localparam int EN_B1_BIT      = 7;
  localparam int EN_B2_BIT      = 6;
  localparam int EN_D_BIT       = 5;
  localparam logic [7:0] REG_RST_VAL = 8'h00;

  // ==========================================================
  // Link timing, in ref_clk cycles
  localparam int LINK_HALF_CYC_DEF = 8;
endpackage

/* tdm_link_if.sv */
// Purpose: TDM serial link between the slot assigner and the backplane end
// Assumes: upstream line is shared, pulled high when nobody drives it
// Notes:   Resolution of the shared line is done here, not in the ends
interface tdm_link_if;
  logic dataClk;
  logic frameSync;
  logic downData;
  logic upData;
  logic upOe;
  logic upLine;

  // ==========================================================
  // Shared line with pull-up
  assign upLine = upOe ? upData : 1'b1;

  modport dev (input dataClk, input frameSync, input downData, output upData, output upOe);
  modport bus (output dataClk, output frameSync, output downData, input upLine);
endinterface

/* sync_2ff.sv */
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: bits are independent levels
// Notes:   First stage is read only by the second
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule

/* slot_assigner.sv */
// Purpose: TDM timeslot assigner placing B1, B2 and D in programmed slots
// Assumes: bus end drives on data clock rise, this end samples on fall
// Notes:   Frame sync high during bit 0; registers over Avalon-MM
// Operation
// - Any slot position for B1, B2, D
// - Frame split into 2-bit slots from zero
// - Host writes first 2-bit slot number
// - Six independent tx/rx start registers
// - Slot registers only while overlay bit0 set
// - Per-channel enables; E0 enables all three
// - GCI 2B+D format selectable by config
// - GCI: eight 32-bit slots per frame
// - GCI slot written as zero-based index
// - GCI slot active only with bit 3
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
module slot_assigner
  import tdm_slot_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  tdm_link_if.dev          link,
  input  wire logic [7:0]  txB1,
  input  wire logic [7:0]  txB2,
  input  wire logic [1:0]  txD,
  output logic      [7:0]  rxB1,
  output logic      [7:0]  rxB2,
  output logic      [1:0]  rxD,
  output logic             rxFrameValid
);
  // ==========================================================
  // Register group
  logic [7:0]  softRst_r, softRst_nxt;
  logic [7:0]  cfg_r, cfg_nxt;
  logic [7:0]  ovlSel_r, ovlSel_nxt;
  logic [7:0]  gci_r, gci_nxt;
  logic [7:0]  slotEn_r, slotEn_nxt;
  logic [7:0]  start_r [0:2*NCH-1];
  logic [7:0]  start_nxt [0:2*NCH-1];
  logic        waitReq_r, waitReq_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic [7:0]  rdSel;
  logic        wrTake;
  logic        overlay;
  logic [CNT_W-1:0] bitCnt_r, bitCnt_nxt;
  logic        locked_r, locked_nxt;

  assign overlay = ovlSel_r[OVL_SEL_BIT];
  // Write lands on the edge where waitrequest is seen low
  assign wrTake  = avs_write && !waitReq_r;

  always_comb begin
    rdSel = 8'h00;
    if (overlay) begin
      if (avs_address < 4'(2*NCH)) rdSel = start_r[3'(avs_address)];
      else if (avs_address == OR_GCI_SLOT) rdSel = gci_r;
      else if (avs_address == OR_SLOT_ENABLE) rdSel = slotEn_r;
      else if (avs_address == OR_OVERLAY_ALIAS) rdSel = ovlSel_r;
    end else begin
      case (avs_address)
        REG_SOFT_RESET:  rdSel = softRst_r;
        REG_CONFIG:      rdSel = cfg_r;
        REG_OVERLAY_SEL: rdSel = ovlSel_r;
        default:         rdSel = 8'h00;
      endcase
    end
  end

  always_comb begin
    softRst_nxt = softRst_r;
    cfg_nxt     = cfg_r;
    ovlSel_nxt  = ovlSel_r;
    gci_nxt     = gci_r;
    slotEn_nxt  = slotEn_r;
    for (int i = 0; i < 2*NCH; i++) start_nxt[i] = start_r[i];
    waitReq_nxt = !((avs_read || avs_write) && waitReq_r);
    rdData_nxt  = rdData_r;
    if ((avs_read || avs_write) && waitReq_r) begin
      rdData_nxt = {24'h000000, rdSel};
      if (!overlay && avs_address == REG_STATUS)
        rdData_nxt = {22'h000000, locked_r, bitCnt_r};
    end
    if (wrTake) begin
      if (overlay) begin
        // Slot numbers stored as written
        if (avs_address < 4'(2*NCH)) start_nxt[3'(avs_address)] = avs_writedata[7:0];
        else if (avs_address == OR_GCI_SLOT) gci_nxt = avs_writedata[7:0];
        else if (avs_address == OR_SLOT_ENABLE) slotEn_nxt = avs_writedata[7:0];
        else if (avs_address == OR_OVERLAY_ALIAS) ovlSel_nxt = avs_writedata[7:0];
      end else begin
        case (avs_address)
          REG_SOFT_RESET:  softRst_nxt = avs_writedata[7:0];
          REG_CONFIG:      cfg_nxt = avs_writedata[7:0];
          REG_OVERLAY_SEL: ovlSel_nxt = avs_writedata[7:0];
          default:         ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      softRst_r <= REG_RST_VAL;
      cfg_r     <= REG_RST_VAL;
      ovlSel_r  <= REG_RST_VAL;
      gci_r     <= REG_RST_VAL;
      slotEn_r  <= REG_RST_VAL;
      for (int i = 0; i < 2*NCH; i++) start_r[i] <= REG_RST_VAL;
      waitReq_r <= 1'b1;
      rdData_r  <= 32'h00000000;
    end else begin
      softRst_r <= softRst_nxt;
      cfg_r     <= cfg_nxt;
      ovlSel_r  <= ovlSel_nxt;
      gci_r     <= gci_nxt;
      slotEn_r  <= slotEn_nxt;
      for (int i = 0; i < 2*NCH; i++) start_r[i] <= start_nxt[i];
      waitReq_r <= waitReq_nxt;
      rdData_r  <= rdData_nxt;
    end
  end

  assign avs_waitrequest = waitReq_r;
  assign avs_readdata    = rdData_r;

  // ==========================================================
  // Link sampling and bit counter
  logic clkS, fsS, dnS;
  logic clkPrev_r;
  logic rise, fall, halted, gciMode;
  logic [CNT_W-1:0] drivePos, samplePos;
  logic [NCH-1:0]   chanOn, txHit, txBit, rxHit;

  sync_2ff #(.W(3)) linkSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({link.dataClk, link.frameSync, link.downData}),
    .q       ({clkS, fsS, dnS})
  );

  assign rise    = clkS && !clkPrev_r;
  assign fall    = !clkS && clkPrev_r;
  assign halted  = softRst_r[SOFT_RST_BIT];
  assign gciMode = cfg_r[CFG_GCI_BIT];
  // Bit driven after this rise is the one sampled at the next fall
  assign drivePos  = (bitCnt_r == CNT_W'(FRAME_BITS - 1)) ? '0 : bitCnt_r + 1'b1;
  assign samplePos = fsS ? '0 : drivePos;

  always_comb begin
    bitCnt_nxt = bitCnt_r;
    locked_nxt = locked_r;
    if (halted) begin
      bitCnt_nxt = CNT_W'(FRAME_BITS - 1);
      locked_nxt = 1'b0;
    end else if (fall) begin
      bitCnt_nxt = samplePos;
      if (fsS) locked_nxt = 1'b1;
    end
  end

  always_comb begin
    if (gciMode) chanOn = {NCH{gci_r[GCI_EN_BIT]}};
    else chanOn = {slotEn_r[EN_D_BIT], slotEn_r[EN_B2_BIT], slotEn_r[EN_B1_BIT]};
  end

  // ==========================================================
  // Per-channel slot windows and data
  logic [7:0] txHold_r [0:NCH-1];
  logic [7:0] txHold_nxt [0:NCH-1];
  logic [7:0] rxAsm_r [0:NCH-1];
  logic [7:0] rxAsm_nxt [0:NCH-1];
  logic [7:0] rxOut_r [0:NCH-1];
  logic [7:0] rxOut_nxt [0:NCH-1];
  logic [7:0] txIn [0:NCH-1];

  assign txIn[0] = txB1;
  assign txIn[1] = txB2;
  assign txIn[2] = {6'h00, txD};

  for (genvar c = 0; c < NCH; c++) begin : gCh
    logic [CNT_W-1:0] txStart, rxStart, txIdx, rxIdx;
    always_comb begin
      if (gciMode) begin
        // 32-bit slot k starts at bit 32k
        txStart = {1'b0, gci_r[2:0], 5'h00} + GCI_OFS[c];
        rxStart = txStart;
      end else begin
        // Slot n covers bits 2n and 2n+1
        txStart = {start_r[c], 1'b0};
        rxStart = {start_r[c+NCH], 1'b0};
      end
      txIdx = drivePos - txStart;
      rxIdx = samplePos - rxStart;
      txHit[c] = chanOn[c] && drivePos >= txStart
                 && {1'b0, drivePos} < {1'b0, txStart} + CH_LEN[c];
      rxHit[c] = chanOn[c] && samplePos >= rxStart
                 && {1'b0, samplePos} < {1'b0, rxStart} + CH_LEN[c];
      txBit[c] = txHold_r[c][3'(CH_LEN[c] - 10'h001 - {7'h00, txIdx[2:0]})];
      txHold_nxt[c] = txHold_r[c];
      rxAsm_nxt[c]  = rxAsm_r[c];
      rxOut_nxt[c]  = rxOut_r[c];
      // Snapshot at bit 0's rise; a channel starting at bit 0 still drives that bit from the previous word
      if (rise && drivePos == '0) txHold_nxt[c] = txIn[c];
      if (fall && !halted) begin
        if (fsS) rxOut_nxt[c] = rxAsm_r[c];
        if (rxHit[c])
          rxAsm_nxt[c][3'(CH_LEN[c] - 10'h001 - {7'h00, rxIdx[2:0]})] = dnS;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        txHold_r[c] <= 8'h00;
        rxAsm_r[c]  <= 8'h00;
        rxOut_r[c]  <= 8'h00;
      end else begin
        txHold_r[c] <= txHold_nxt[c];
        rxAsm_r[c]  <= rxAsm_nxt[c];
        rxOut_r[c]  <= rxOut_nxt[c];
      end
    end
  end

  // ==========================================================
  // Upstream driver and frame strobe
  logic upData_r, upData_nxt, upOe_r, upOe_nxt, rxValid_r, rxValid_nxt;

  always_comb begin
    upData_nxt  = upData_r;
    upOe_nxt    = upOe_r;
    rxValid_nxt = fall && fsS && !halted && locked_r;
    if (halted || !locked_r) begin
      upOe_nxt = 1'b0;
    end else if (rise) begin
      upOe_nxt   = |txHit;
      upData_nxt = |(txHit & txBit);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clkPrev_r <= 1'b0;
      bitCnt_r  <= CNT_W'(FRAME_BITS - 1);
      locked_r  <= 1'b0;
      upData_r  <= 1'b1;
      upOe_r    <= 1'b0;
      rxValid_r <= 1'b0;
    end else begin
      clkPrev_r <= clkS;
      bitCnt_r  <= bitCnt_nxt;
      locked_r  <= locked_nxt;
      upData_r  <= upData_nxt;
      upOe_r    <= upOe_nxt;
      rxValid_r <= rxValid_nxt;
    end
  end

  assign link.upData  = upData_r;
  assign link.upOe    = upOe_r;
  assign rxB1         = rxOut_r[0];
  assign rxB2         = rxOut_r[1];
  assign rxD          = rxOut_r[2][1:0];
  assign rxFrameValid = rxValid_r;
endmodule

/* tdm_bus_end.sv */
// Purpose: Backplane end of the TDM link: makes data clock and frame sync
// Assumes: user supplies one bit per bit time, ahead of its rise
// Notes:   Upstream sampled late in the bit to cover the far end's latency
module tdm_bus_end
  import tdm_slot_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC_DEF
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  tdm_link_if.bus               link,
  input  wire logic             txBit,
  output logic      [CNT_W-1:0] bitPos,
  output logic                  rxBit,
  output logic      [CNT_W-1:0] rxPos,
  output logic                  rxStrobe
);
  // ==========================================================
  // Clock divider and frame counter
  logic [7:0]       phase_r, phase_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, nextCnt;
  logic             clk_r, clk_nxt, fs_r, fs_nxt, dn_r, dn_nxt;
  logic             rxBit_r, rxBit_nxt, rxStb_r, rxStb_nxt;
  logic [CNT_W-1:0] rxPos_r, rxPos_nxt;
  logic [CNT_W-1:0] bitPos_r, bitPos_nxt;
  logic             upS;

  sync_2ff #(.W(1)) upSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (link.upLine),
    .q       (upS)
  );

  assign nextCnt = (cnt_r == CNT_W'(FRAME_BITS - 1)) ? '0 : cnt_r + 1'b1;

  always_comb begin
    phase_nxt = (phase_r == 8'(2*HALF_CYC - 1)) ? 8'h00 : phase_r + 8'h01;
    cnt_nxt   = cnt_r;
    clk_nxt   = clk_r;
    fs_nxt    = fs_r;
    dn_nxt    = dn_r;
    rxBit_nxt = rxBit_r;
    rxPos_nxt = rxPos_r;
    rxStb_nxt = 1'b0;
    // One cycle late, still ahead of the rise while a bit lasts >= 4 cycles
    bitPos_nxt = nextCnt;
    if (phase_r == 8'h00) begin
      clk_nxt = 1'b1;
      cnt_nxt = nextCnt;
      fs_nxt  = (nextCnt == '0);
      dn_nxt  = txBit;
    end else if (phase_r == 8'(HALF_CYC)) begin
      clk_nxt = 1'b0;
    end else if (phase_r == 8'(2*HALF_CYC - 1)) begin
      rxBit_nxt = upS;
      rxPos_nxt = cnt_r;
      rxStb_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_r <= 8'h00;
      cnt_r   <= CNT_W'(FRAME_BITS - 1);
      clk_r   <= 1'b0;
      fs_r    <= 1'b0;
      dn_r    <= 1'b1;
      rxBit_r <= 1'b1;
      rxPos_r <= '0;
      rxStb_r <= 1'b0;
      bitPos_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r   <= cnt_nxt;
      clk_r   <= clk_nxt;
      fs_r    <= fs_nxt;
      dn_r    <= dn_nxt;
      rxBit_r <= rxBit_nxt;
      rxPos_r <= rxPos_nxt;
      rxStb_r <= rxStb_nxt;
      bitPos_r <= bitPos_nxt;
    end
  end

  assign link.dataClk   = clk_r;
  assign link.frameSync = fs_r;
  assign link.downData  = dn_r;
  assign bitPos         = bitPos_r;
  assign rxBit          = rxBit_r;
  assign rxPos          = rxPos_r;
  assign rxStrobe       = rxStb_r;
endmodule

/* tdm_timeslot_assigner_assertions.sv */
// Purpose: Link-side checks between the slot assigner and the bus end
// Assumes: one ref_clk domain; the bus end makes the link clock
// Notes:   ph_r counts ref_clk cycles since the last link clock rise
module tdm_timeslot_assigner_assertions
  import tdm_slot_pkg::*;
#(
  parameter int HALF_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dataClk,
  input wire logic frameSync,
  input wire logic downData,
  input wire logic upData,
  input wire logic upOe,
  input wire logic upLine
);
  logic [7:0]  ph_r;
  logic [15:0] fc_r;
  logic        dc_r;
  logic        fs_r;
  logic        run_r;
  logic        lock_r;

  // ==========================================================
  // Helper counters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ph_r <= 8'h00;
      fc_r <= 16'h0000;
      dc_r <= 1'b0;
      fs_r <= 1'b0;
      run_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      dc_r <= dataClk;
      fs_r <= frameSync;
      ph_r <= (dataClk && !dc_r) ? 8'h01 : ph_r + 8'h01;
      fc_r <= (frameSync && !fs_r) ? 16'h0001 : fc_r + 16'h0001;
      if (dataClk && !dc_r) run_r <= 1'b1;
      if (frameSync) lock_r <= 1'b1;
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  clk_high_a: assert property ($fell(dataClk) |-> ph_r == 8'(HALF_CYC))
    else $error("link clock high time wrong");
  clk_period_a: assert property ($rose(dataClk) && run_r |-> ph_r == 8'(2 * HALF_CYC))
    else $error("link clock period wrong");
  sync_rise_a: assert property ($rose(frameSync) |-> $rose(dataClk))
    else $error("frame sync rose off a clock rise");
  sync_width_a: assert property ($fell(frameSync) |-> $rose(dataClk) && ph_r == 8'(2 * HALF_CYC))
    else $error("frame sync not one bit wide");
  frame_len_a: assert property ($rose(frameSync) && lock_r |-> fc_r == 16'(2 * HALF_CYC * FRAME_BITS))
    else $error("frame length wrong");
  down_timing_a: assert property ($changed(downData) |-> $rose(dataClk))
    else $error("downstream bit changed off a clock rise");
  oe_timing_a: assert property ($changed(upOe) |-> ph_r inside {[2:5]})
    else $error("upstream enable changed mid bit");
  data_timing_a: assert property ($changed(upData) |-> ph_r inside {[2:5]})
    else $error("upstream data changed mid bit");
  unlocked_quiet_a: assert property (!lock_r |-> !upOe)
    else $error("upstream driven before any frame sync");
  idle_pull_a: assert property (!upOe |-> upLine)
    else $error("released line not high");
  oe_hold_a: assert property ($rose(upOe) |-> upOe [*7])
    else $error("upstream enable dropped inside a bit");

  cover property ($rose(upOe));
  cover property ($rose(frameSync) && lock_r);
  cover property (upOe && !upLine);
endmodule

/* tdm_timeslot_assigner_tb_top.sv */
// Purpose: Self-checking bench joining the slot assigner to the bus end
// Assumes: bus end at HALF_CYC 4, so one frame is 4096 ref_clk cycles
// Notes:   Bench fills the downstream frame and records the upstream one
module tdm_timeslot_assigner_tb_top
  import tdm_slot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 4;
  localparam logic [7:0] ST [0:5] = '{8'h08, 8'h0c, 8'h11, 8'h40, 8'h44, 8'hff};
  logic             ref_clk;
  logic             rst;
  logic [3:0]       avs_address;
  logic             avs_read;
  logic             avs_write;
  logic [31:0]      avs_writedata;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [7:0]       txB1;
  logic [7:0]       txB2;
  logic [1:0]       txD;
  logic [7:0]       rxB1;
  logic [7:0]       rxB2;
  logic [1:0]       rxD;
  logic             rxFrameValid;
  logic             txBit;
  logic [CNT_W-1:0] bitPos;
  logic             rxBit;
  logic [CNT_W-1:0] rxPos;
  logic             rxStrobe;
  logic             downFrame [0:FRAME_BITS-1];
  logic             upFrame [0:FRAME_BITS-1];
  int               bad_count = 0;
  int               n_tests = 0;

  // ==========================================================
  // Ends, link and checker
  tdm_link_if link();
  slot_assigner slot_assigner_inst (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link), .txB1(txB1),
    .txB2(txB2), .txD(txD), .rxB1(rxB1), .rxB2(rxB2), .rxD(rxD), .rxFrameValid(rxFrameValid));
  tdm_bus_end #(.HALF_CYC(HC)) tdm_bus_end_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
    .txBit(txBit), .bitPos(bitPos), .rxBit(rxBit), .rxPos(rxPos), .rxStrobe(rxStrobe));
  tdm_timeslot_assigner_assertions #(.HALF_CYC(HC)) tdm_timeslot_assigner_assertions_inst (
    .ref_clk(ref_clk), .rst(rst), .dataClk(link.dataClk), .frameSync(link.frameSync),
    .downData(link.downData), .upData(link.upData), .upOe(link.upOe), .upLine(link.upLine));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) txBit <= downFrame[bitPos];
  always @(posedge ref_clk) if (rxStrobe) upFrame[rxPos] <= rxBit;

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0);
    // Answer is due on the second edge after the request is driven, where waitrequest is seen low
    chk("wait cycles", 32'h00000002, 32'(k));
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask
  task automatic wait_frame();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rxFrameValid !== 1'b1 && k < 6000);
    chk("frame pulse", 32'h1, {31'h0, rxFrameValid});
  endtask
  task automatic check_ch(input string nm, input int txS, input int rxS, input int len,
                          input logic [7:0] tv, input logic en, input logic [7:0] rw);
    logic [7:0] e;
    logic [7:0] g;
    logic [7:0] r;
    e = 8'h00;
    g = 8'h00;
    r = 8'h00;
    for (int i = 0; i < len; i++) begin
      e[len-1-i] = en ? tv[len-1-i] : 1'b1;
      g[len-1-i] = upFrame[txS+i];
      r[len-1-i] = downFrame[rxS+i];
    end
    chk({nm, " tx"}, {24'h0, e}, {24'h0, g});
    if (en) chk({nm, " rx"}, {24'h0, r}, {24'h0, rw});
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_regs();
    rd("overlay", REG_OVERLAY_SEL, 8'h00);
    wr(4'h3, 8'h5a);
    rd("unmapped", 4'h3, 8'h00);
    wr(OR_GCI_SLOT, 8'h0b);
    wr(REG_OVERLAY_SEL, 8'h01);
    rd("gci hidden", OR_GCI_SLOT, 8'h00);
    for (int k = 0; k < 6; k++) wr(OR_START_BASE + 4'(k), ST[k]);
    for (int k = 0; k < 6; k++) rd("start", OR_START_BASE + 4'(k), ST[k]);
    rd("alias", OR_OVERLAY_ALIAS, 8'h01);
    wr(OR_OVERLAY_ALIAS, 8'h00);
    $display("register test done");
  endtask
  task automatic test_halt();
    logic [31:0] q;
    wr(REG_SOFT_RESET, 8'h08);
    xfer(1'b0, REG_STATUS, 8'h00, q);
    chk("halted status", {22'h0, 1'b0, 9'(FRAME_BITS - 1)}, q);
    wr(REG_SOFT_RESET, 8'h00);
    // Relock needs a whole frame before the strobe can come
    repeat (2 * HC * FRAME_BITS) @(posedge ref_clk);
    wait_frame();
    xfer(1'b0, REG_STATUS, 8'h00, q);
    chk("relocked status", 32'h00000200, q);
    $display("halt test done");
  endtask
  task automatic test_native(input logic [7:0] en);
    wr(REG_OVERLAY_SEL, 8'h01);
    wr(OR_SLOT_ENABLE, en);
    rd("enable", OR_SLOT_ENABLE, en);
    wr(OR_OVERLAY_ALIAS, 8'h00);
    wait_frame();
    wait_frame();
    check_ch("b1", SLOT_BITS * ST[0], SLOT_BITS * ST[3], 8, txB1, en[EN_B1_BIT], rxB1);
    check_ch("b2", SLOT_BITS * ST[1], SLOT_BITS * ST[4], 8, txB2, en[EN_B2_BIT], rxB2);
    check_ch("d", SLOT_BITS * ST[2], SLOT_BITS * ST[5], 2, {6'h0, txD}, en[EN_D_BIT], {6'h0, rxD});
    check_ch("gap", 40, 0, 8, 8'h00, 1'b0, 8'h00);
    $display("native test with enable %h done", en);
  endtask
  task automatic test_gci(input logic [7:0] v, input logic en);
    int b;
    b = GCI_SLOT_W * v[2:0];
    wr(REG_OVERLAY_SEL, 8'h01);
    wr(OR_GCI_SLOT, v);
    wr(OR_OVERLAY_ALIAS, 8'h00);
    wait_frame();
    wait_frame();
    check_ch("gci b1", b + GCI_OFS[0], b + GCI_OFS[0], 8, txB1, en, rxB1);
    check_ch("gci b2", b + GCI_OFS[1], b + GCI_OFS[1], 8, txB2, en, rxB2);
    check_ch("gci d", b + GCI_OFS[2], b + GCI_OFS[2], 2, {6'h0, txD}, en, {6'h0, rxD});
    check_ch("gci gap", 40, 0, 8, 8'h00, 1'b0, 8'h00);
    $display("gci test with slot value %h done", v);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    txB1 = 8'ha5;
    txB2 = 8'h3c;
    txD = 2'h2;
    for (int i = 0; i < FRAME_BITS; i++) begin
      downFrame[i] = i[0] ^ i[3] ^ i[6];
    end
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    test_regs();
    test_halt();
    test_native(8'he0);
    test_native(8'h80);
    test_native(8'h40);
    test_native(8'h20);
    wr(REG_CONFIG, 8'h01);
    test_gci(8'h03, 1'b0);
    test_gci(8'h0b, 1'b1);
    final_report();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    $display("BAD watchdog expected done seen timeout");
    final_report();
  end
endmodule
